// File: verilog/sbs_burst_sram.sv
`timescale 1ns/1ps
//
// Contract
// RULE_01: 32768 words of 18 bits, shared data pins
// RULE_02: address, data, controls registered on rising edge
// RULE_03: processor start aborts burst, begins read
// RULE_04: master writes in cycle after processor start
// RULE_05: controller start begins write or read burst
// RULE_06: chip enable sampled on loads; high deselects
// RULE_07: advance low steps address before access
// RULE_08: advance high holds address, wait state
// RULE_09: continued burst writes or reads next address
// RULE_10: suspended cycle still writes or reads current
// RULE_11: two-bit counter on low address bits only
// RULE_12: external low bits seed the burst counter
// RULE_13: four accesses wrap back to start value
// RULE_14: low enable bits 0-8, high bits 9-17
// RULE_15: write self-timed from sampling clock edge; the array here commits the write on the next rising edge
// RULE_16: drive pins only on read, output enable low
// RULE_17: master raises output enable before writes
// RULE_18: pins high-impedance from power-up until read
// RULE_19: burst order ascending modulo four
// RULE_20: read data valid same cycle, no output register

module sbs_burst_sram
    import sbs_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire logic [SBS_ADDR_W-1:0] word_address,
    input  wire logic [SBS_DATA_W-1:0] data_in,
    output logic      [SBS_DATA_W-1:0] data_out,
    output logic                       data_oe,
    input  wire logic                  chip_enable_n,
    input  wire logic                  output_enable_n,
    input  wire logic                  proc_burst_start_n,
    input  wire logic                  ctrl_burst_start_n,
    input  wire logic                  burst_advance_n,
    input  wire logic                  low_byte_write_n,
    input  wire logic                  high_byte_write_n
);

    // registered state
    logic                   selected;
    sbs_op_e                op;
    logic [SBS_BASE_W-1:0]  base;
    logic [SBS_BURST_W-1:0] burst_low;
    logic [SBS_DATA_W-1:0]  wdata;
    logic [SBS_LANES-1:0]   lanes;

    // decode of the sampled controls
    logic                   load_proc;
    logic                   load_ctrl;
    logic                   load;
    logic                   any_write;
    logic                   advance;
    logic                   next_selected;
    sbs_op_e                next_op;
    logic [SBS_BASE_W-1:0]  next_base;
    logic [SBS_BURST_W-1:0] next_burst_low;
    logic [SBS_BURST_W-1:0] stepped_low;
    logic [SBS_LANES-1:0]   next_lanes;
    logic [SBS_ADDR_W-1:0]  access_addr;
    logic [SBS_DATA_W-1:0]  array_rdata;
    logic                   write_now;
    logic                   drive;

    assign load_proc = ~proc_burst_start_n;                              // [RULE_03]
    assign load_ctrl = proc_burst_start_n & ~ctrl_burst_start_n;         // [RULE_05]
    assign load      = load_proc | load_ctrl;
    assign any_write = ~low_byte_write_n | ~high_byte_write_n;           // [RULE_14]
    assign advance   = ~load & ~burst_advance_n & selected;              // [RULE_07] [RULE_08]

    assign stepped_low = burst_low + SBS_BURST_STEP;                     // [RULE_11] [RULE_13] [RULE_19]

    // chip enable only matters on a load
    assign next_selected = load ? ~chip_enable_n : selected;             // [RULE_06]

    assign next_base      = load ? word_address[SBS_ADDR_W-1:SBS_BURST_W] : base;   // [RULE_11]
    assign next_burst_low = load    ? word_address[SBS_BURST_W-1:0] :               // [RULE_12]
                            advance ? stepped_low : burst_low;                       // [RULE_07] [RULE_08]

    assign next_lanes = {~high_byte_write_n, ~low_byte_write_n};         // [RULE_14]

    always_comb begin
        if (load) begin
            if (chip_enable_n) begin
                next_op = SBS_OP_IDLE;                                   // [RULE_06]
            end else if (load_proc) begin
                next_op = SBS_OP_READ;                                   // [RULE_03]
            end else begin
                next_op = any_write ? SBS_OP_WRITE : SBS_OP_READ;        // [RULE_05]
            end
        end else if (selected) begin
            // continue or suspend: write on any lane, else read
            next_op = any_write ? SBS_OP_WRITE : SBS_OP_READ;            // [RULE_09] [RULE_10] [RULE_04]
        end else begin
            next_op = SBS_OP_IDLE;
        end
    end

    // input register stage
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            selected  <= 1'b0;
            op        <= SBS_OP_IDLE;
            base      <= SBS_BASE_RST;
            burst_low <= SBS_BURST_RST;
            wdata     <= SBS_DATA_RST;
            lanes     <= SBS_LANE_RST;
        end else begin
            selected  <= next_selected;                                  // [RULE_02]
            op        <= next_op;                                        // [RULE_02]
            base      <= next_base;                                      // [RULE_02]
            burst_low <= next_burst_low;                                 // [RULE_02]
            wdata     <= data_in;                                        // [RULE_02]
            lanes     <= next_lanes;                                     // [RULE_02]
        end
    end

    assign access_addr = {base, burst_low};
    assign write_now   = (op == SBS_OP_WRITE);                           // [RULE_15]

    sbs_word_array #(
        .ADDR_W (SBS_ADDR_W),
        .DEPTH  (SBS_DEPTH),
        .LANE_W (SBS_LANE_W),
        .LANES  (SBS_LANES)
    ) u_array (
        .sys_clk    (sys_clk),
        .write_en   (write_now),                                         // [RULE_01] [RULE_15]
        .lane_en    (lanes),                                             // [RULE_14]
        .addr       (access_addr),
        .write_data (wdata),
        .read_data  (array_rdata)
    );

    // output enable acts without the clock; pins float otherwise
    assign drive    = (op == SBS_OP_READ) & ~output_enable_n;            // [RULE_16] [RULE_18]
    assign data_oe  = drive;                                             // [RULE_16]
    assign data_out = drive ? array_rdata : SBS_DATA_RST;                // [RULE_20]

endmodule

// File: verilog/sbs_pkg.sv
package sbs_pkg;

    // array organisation
    localparam int unsigned SBS_ADDR_W  = 15;
    localparam int unsigned SBS_DATA_W  = 18;
    localparam int unsigned SBS_DEPTH   = 32768;
    localparam int unsigned SBS_LANE_W  = 9;
    localparam int unsigned SBS_LANES   = 2;

    // burst counter covers the low address bits only
    localparam int unsigned SBS_BURST_W = 2;
    localparam int unsigned SBS_BASE_W  = SBS_ADDR_W - SBS_BURST_W;

    // reset values of the control state, and the burst counter step
    localparam logic [SBS_BURST_W-1:0] SBS_BURST_RST = 2'h0;
    localparam logic [SBS_BURST_W-1:0] SBS_BURST_STEP = 2'h1;
    localparam logic [SBS_BASE_W-1:0]  SBS_BASE_RST  = 13'h0000;
    localparam logic [SBS_DATA_W-1:0]  SBS_DATA_RST  = 18'h00000;
    localparam logic [SBS_LANES-1:0]   SBS_LANE_RST  = 2'h0;

    // operation performed in the cycle after a clock edge
    typedef enum logic [1:0] {
        SBS_OP_IDLE,
        SBS_OP_READ,
        SBS_OP_WRITE
    } sbs_op_e;

endpackage

// File: verilog/sbs_word_array.sv
`timescale 1ns/1ps

module sbs_word_array
    import sbs_pkg::*;
#(
    parameter int unsigned ADDR_W = SBS_ADDR_W,
    parameter int unsigned DEPTH  = SBS_DEPTH,
    parameter int unsigned LANE_W = SBS_LANE_W,
    parameter int unsigned LANES  = SBS_LANES
) (
    input  wire logic                      sys_clk,
    input  wire logic                      write_en,
    input  wire logic [LANES-1:0]          lane_en,
    input  wire logic [ADDR_W-1:0]         addr,
    input  wire logic [LANE_W*LANES-1:0]   write_data,
    output logic      [LANE_W*LANES-1:0]   read_data
);

    // each lane keeps its own array so that no word has two writing processes
    generate
        for (genvar lane = 0; lane < LANES; lane++) begin : g_lane
            logic [LANE_W-1:0] store [DEPTH];

            // lane commits on the edge after its request was registered
            always_ff @(posedge sys_clk) begin
                if (write_en && lane_en[lane]) begin
                    store[addr] <= write_data[lane*LANE_W +: LANE_W];
                end
            end

            // flow-through read of the registered address
            assign read_data[lane*LANE_W +: LANE_W] = store[addr];
        end
    endgenerate

endmodule

// File: sim/sbs_burst_sram_chk.sv
`timescale 1ns/1ps
module sbs_burst_sram_chk
    import sbs_pkg::*;
(
    input wire logic                  sys_clk,
    input wire logic                  rst,
    input wire logic [SBS_ADDR_W-1:0] word_address,
    input wire logic [SBS_DATA_W-1:0] data_in,
    input wire logic [SBS_DATA_W-1:0] data_out,
    input wire logic                  data_oe,
    input wire logic                  chip_enable_n,
    input wire logic                  output_enable_n,
    input wire logic                  proc_burst_start_n,
    input wire logic                  ctrl_burst_start_n,
    input wire logic                  burst_advance_n,
    input wire logic                  low_byte_write_n,
    input wire logic                  high_byte_write_n
);
    logic any_wr;
    assign any_wr = !(low_byte_write_n && high_byte_write_n);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_cont; proc_burst_start_n && ctrl_burst_start_n; endsequence
    sequence s_ctrl; proc_burst_start_n && !ctrl_burst_start_n && !chip_enable_n; endsequence
    property p_oe_gate; data_oe |-> !output_enable_n; endproperty
    a_oe_gate: assert property (p_oe_gate) else $error("pins driven with output enable high");
    property p_out_idle; !data_oe |-> data_out == SBS_DATA_RST; endproperty
    a_out_idle: assert property (p_out_idle) else $error("read data not zero when idle");
    property p_proc_read; !proc_burst_start_n && !chip_enable_n ##1 !output_enable_n |-> data_oe; endproperty
    a_proc_read: assert property (p_proc_read) else $error("processor start did not read");
    property p_ctrl_read; s_ctrl ##0 !any_wr ##1 !output_enable_n |-> data_oe; endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("controller read start missing");
    property p_ctrl_write; s_ctrl ##0 any_wr |=> !data_oe; endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("controller write drove pins");
    property p_desel; chip_enable_n && !(proc_burst_start_n && ctrl_burst_start_n) |=> !data_oe; endproperty
    a_desel: assert property (p_desel) else $error("deselected device drove pins");
    property p_cont_write; s_cont ##0 any_wr |=> !data_oe; endproperty
    a_cont_write: assert property (p_cont_write) else $error("burst write drove pins");
    property p_suspend;
        data_oe ##0 s_cont ##0 burst_advance_n && !any_wr ##1 !output_enable_n |-> data_oe && $stable(data_out);
    endproperty
    a_suspend: assert property (p_suspend) else $error("suspend changed read word");
endmodule

bind sbs_burst_sram sbs_burst_sram_chk u_chk (.sys_clk, .rst, .word_address, .data_in, .data_out, .data_oe,
    .chip_enable_n, .output_enable_n, .proc_burst_start_n, .ctrl_burst_start_n, .burst_advance_n,
    .low_byte_write_n, .high_byte_write_n);

// File: sim/sbs_bus_model.sv
`timescale 1ns/1ps
module sbs_bus_model
    import sbs_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  drv_en,
    input  wire logic [SBS_DATA_W-1:0] drv_val,
    input  wire logic [SBS_DATA_W-1:0] data_out,
    input  wire logic                  data_oe,
    output logic      [SBS_DATA_W-1:0] data_in
);
    logic [SBS_DATA_W-1:0] last;
    // shared pins: master, else device, else a floating pattern
    assign data_in = drv_en ? drv_val : (data_oe ? data_out : ~last);
    always @(posedge sys_clk) begin
        last <= data_in;
    end
endmodule

// File: sim/sbs_burst_sram_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_count++; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module sbs_burst_sram_tb
    import sbs_pkg::*;
;
    logic        sys_clk, rst, ce_n, oe_n, ps_n, cs_n, adv_n, lw_n, hw_n, drv_en, sel = 0;
    logic [14:0] addr, ad, a;
    logic [17:0] data_in, data_out, drv_val, mem [32768];
    logic        data_oe;
    int          err_count = 0, checks = 0, n, i;
    sbs_burst_sram u_dut (.sys_clk, .rst, .word_address(addr), .data_in, .data_out, .data_oe,
        .chip_enable_n(ce_n), .output_enable_n(oe_n), .proc_burst_start_n(ps_n), .ctrl_burst_start_n(cs_n),
        .burst_advance_n(adv_n), .low_byte_write_n(lw_n), .high_byte_write_n(hw_n));
    sbs_bus_model u_bus (.sys_clk, .drv_en, .drv_val, .data_out, .data_oe, .data_in);
    function automatic logic [17:0] f_merge(logic [17:0] o, logic [17:0] d, logic l, logic h);
        return {h ? o[17:9] : d[17:9], l ? o[8:0] : d[8:0]};
    endfunction
    task automatic step(input logic ps, cs, adv, lw, hw, ce, input logic [14:0] wa);
        logic ld, wq, eo;
        logic [17:0] d;
        ld = !ps || !cs;
        wq = (ld ? ps : 1'b1) && !(lw && hw);
        d = 18'($urandom);
        {ps_n, cs_n, adv_n, lw_n, hw_n, ce_n, addr} = {ps, cs, adv, lw, hw, ce, wa};
        oe_n = wq || ($urandom % 4 == 0);
        drv_en = wq;
        drv_val = d;
        @(posedge sys_clk);
        #1;
        if (ld) begin
            sel = !ce;
            ad = wa;
        end else if (sel && !adv) ad[1:0] = ad[1:0] + 2'h1;
        if (sel && wq) mem[ad] = f_merge(mem[ad], d, lw, hw);
        eo = sel && !wq && !oe_n;
        `CHK("data_oe", eo, data_oe)
        `CHK("data_out", eo ? mem[ad] : SBS_DATA_RST, data_out)
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        sys_clk = 0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        #100000;
        err_count++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'h6074));
        {rst, ce_n, oe_n, ps_n, cs_n, adv_n, lw_n, hw_n, drv_en, addr, drv_val} = {9'h1FF, 15'h0000, 18'h00000};
        repeat (3) @(posedge sys_clk);
        #1 rst = 0;
        @(posedge sys_clk);
        #1;
        `CHK("data_oe", 1'b0, data_oe)
        step(1, 0, 1, 0, 0, 1, 15'h0005);
        step(1, 1, 0, 0, 0, 0, 15'h0005);
        for (n = 0; n < 40; n++) begin
            a = 15'($urandom);
            step(1, 0, 1, 0, 0, 0, a);
            for (i = 0; i < 3; i++) step(1, 1, 0, 0, 0, 0, a);
            step(1, 0, 1, 1, 1, 0, a);
            for (i = 0; i < 6; i++) step(1, 1, 1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom), a);
            step(0, 1'($urandom), 1, 1'($urandom), 1'($urandom), 1'(n % 5 == 0), a);
            for (i = 0; i < 5; i++) step(1, 1, 0, 1, 1, 0, a);
            step(0, 1, 1, 1, 1, 0, a);
            step(1, 1, 1, 0, 1, 0, a);
            step(1, 1, 1, 1, 1, 0, a);
        end
        print_verdict();
    end
endmodule
